/* File: rtl/rdt_cfg.svh */
// constants for the resonant dead time edge placement block
// assumes a 100 MHz hclk and word-aligned AHB-Lite register access
`ifndef RDT_CFG_SVH
`define RDT_CFG_SVH

`define RDT_IDX_PWM_D_FALL  8'h4f
`define RDT_IDX_RECT1_RISE  8'h51
`define RDT_IDX_RECT1_FALL  8'h53
`define RDT_IDX_CTRL        8'h60
`define RDT_IDX_STATUS      8'h61
`define RDT_CTRL_RES_BIT    0
`define RDT_OFS_RESET       8'h00
`define RDT_STEP_NS         5
`define RDT_CLK_NS          10
`define RDT_CNT_W           16

`endif

/* File: rtl/rdt_pkg.sv */
// types shared by the resonant dead time block
// assumes rdt_cfg.svh supplies the numeric constants
`include "rdt_cfg.svh"
package rdt_pkg;
  typedef logic [7:0]              rdt_code_t;
  typedef logic [`RDT_CNT_W-1:0]   rdt_cnt_t;

  typedef struct packed {
    rdt_code_t pwm_d_fall_offset;
    rdt_code_t rect1_rise_offset;
    rdt_code_t rect1_fall_offset;
  } rdt_ofs_s;

  typedef struct packed {
    logic       sel;
    logic       write;
    logic [7:0] idx;
  } rdt_aphase_s;
endpackage

/* File: rtl/rdt_timing.sv */
// edge placement for the fourth pwm output and the first rectifier drive
// assumes cycle_start and pwm_d_in come from the cycle generator on hclk
`include "rdt_cfg.svh"
`timescale 1ns/1ps
module rdt_timing
  import rdt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cycle_start,
  input  wire logic        pwm_d_in,
  input  wire logic        ac_sense_input,
  output logic             fourth_pwm_output,
  output logic             first_rectifier_drive
);

  // code to whole clock cycles, rounded up
  function automatic rdt_cnt_t code_cyc(input rdt_code_t c);
    logic [15:0] ns;
    ns = 16'(c) * 16'(`RDT_STEP_NS);
    code_cyc = rdt_cnt_t'((ns + 16'(`RDT_CLK_NS) - 16'h0001) / 16'(`RDT_CLK_NS));
  endfunction

  rdt_ofs_s    ofs_r;
  rdt_ofs_s    shd_r;
  logic        res_mode_r;
  rdt_aphase_s ap_r;
  logic        sense_s1_r;
  logic        sense_s2_r;
  logic        sense_d_r;
  rdt_cnt_t    cyc_cnt_r;
  rdt_cnt_t    period_r;
  rdt_cnt_t    hi_cnt_r;
  rdt_cnt_t    hi_len_r;
  logic        sense_rise;
  logic        sense_fall;
  logic        pwm_d_nxt;
  logic        rect_nxt;
  rdt_cnt_t    d_lead;
  rdt_cnt_t    r_dly;
  rdt_cnt_t    r_lead;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_r <= '0;
    end else if (hready) begin
      ap_r.sel   <= hsel & htrans[1];
      ap_r.write <= hwrite;
      ap_r.idx   <= haddr[9:2];
    end
  end

  // register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ofs_r      <= {3{`RDT_OFS_RESET}};
      res_mode_r <= 1'b0;
    end else if (ap_r.sel && ap_r.write) begin
      // only the low byte is kept, upper write bits are dropped
      case (ap_r.idx)
        `RDT_IDX_PWM_D_FALL: begin
          ofs_r.pwm_d_fall_offset <= hwdata[7:0];
        end
        `RDT_IDX_RECT1_RISE: begin
          ofs_r.rect1_rise_offset <= hwdata[7:0];
        end
        `RDT_IDX_RECT1_FALL: begin
          ofs_r.rect1_fall_offset <= hwdata[7:0];
        end
        `RDT_IDX_CTRL: begin
          res_mode_r <= hwdata[`RDT_CTRL_RES_BIT];
        end
        default: ;
      endcase
    end
  end

  // read data registered from the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      hrdata <= 32'h0000_0000;
      if (hsel && htrans[1] && !hwrite) begin
        // readback shows the written value, not the shadow in use
        case (haddr[9:2])
          `RDT_IDX_PWM_D_FALL: begin
            hrdata <= {24'h00_0000, ofs_r.pwm_d_fall_offset};
          end
          `RDT_IDX_RECT1_RISE: begin
            hrdata <= {24'h00_0000, ofs_r.rect1_rise_offset};
          end
          `RDT_IDX_RECT1_FALL: begin
            hrdata <= {24'h00_0000, ofs_r.rect1_fall_offset};
          end
          `RDT_IDX_CTRL: begin
            hrdata <= {31'h0000_0000, res_mode_r};
          end
          `RDT_IDX_STATUS: begin
            hrdata <= {29'h0000_0000, sense_s2_r,
                       first_rectifier_drive, fourth_pwm_output};
          end
          default: begin
            hrdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // shadow copies follow the written values only at a cycle boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shd_r <= {3{`RDT_OFS_RESET}};
    end else if (cycle_start) begin
      shd_r <= ofs_r;
    end
  end

  // sense pin synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_s1_r <= 1'b0;
      sense_s2_r <= 1'b0;
      sense_d_r  <= 1'b0;
    end else begin
      sense_s1_r <= ac_sense_input;
      sense_s2_r <= sense_s1_r;
      sense_d_r  <= sense_s2_r;
    end
  end

  assign sense_rise = sense_s2_r & ~sense_d_r;
  assign sense_fall = ~sense_s2_r & sense_d_r;

  // switching period measurement, predicts cycle_end_point
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_cnt_r <= '0;
      period_r  <= '0;
    end else if (cycle_start) begin
      cyc_cnt_r <= rdt_cnt_t'(1);
      period_r  <= cyc_cnt_r;
    end else if (cyc_cnt_r != '1) begin
      cyc_cnt_r <= cyc_cnt_r + rdt_cnt_t'(1);
    end
  end

  // sense high time measurement, predicts sense_fall_point
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_cnt_r <= '0;
      hi_len_r <= '0;
    end else if (sense_rise) begin
      hi_cnt_r <= '0;
    end else if (sense_fall) begin
      hi_len_r <= hi_cnt_r;
    end else if (sense_s2_r && hi_cnt_r != '1) begin
      hi_cnt_r <= hi_cnt_r + rdt_cnt_t'(1);
    end
  end

  assign d_lead = code_cyc(shd_r.pwm_d_fall_offset);
  assign r_dly  = code_cyc(shd_r.rect1_rise_offset);
  assign r_lead = code_cyc(shd_r.rect1_fall_offset);

  // fourth output: pass through unless resonant mode
  always_comb begin
    pwm_d_nxt = pwm_d_in;
    if (res_mode_r) begin
      // drop early once within the lead of the predicted end point
      pwm_d_nxt = pwm_d_in && !cycle_start &&
                  ({1'b0, cyc_cnt_r} + {1'b0, d_lead} < {1'b0, period_r});
    end
  end

  // rectifier drive: follows synced sense unless resonant mode
  always_comb begin
    rect_nxt = sense_s2_r;
    if (res_mode_r) begin
      // late rise after sense rise, early fall from last high time
      rect_nxt = sense_s2_r && !sense_rise && (hi_cnt_r >= r_dly) &&
                 ({1'b0, hi_cnt_r} + {1'b0, r_lead} < {1'b0, hi_len_r});
    end
  end

  // registered fourth output, no glitches toward the gate driver
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fourth_pwm_output <= 1'b0;
    end else begin
      fourth_pwm_output <= pwm_d_nxt;
    end
  end

  // registered rectifier drive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_rectifier_drive <= 1'b0;
    end else begin
      first_rectifier_drive <= rect_nxt;
    end
  end

endmodule

/* File: testbench/rdt_timing_monitor.sv */
// checker on the edge placement ports
// assumes long stable input levels
`timescale 1ns/1ps
module rdt_timing_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [31:0] hrdata,
  input wire logic        pwm_d_in,
  input wire logic        ac_sense_input,
  input wire logic        fourth_pwm_output,
  input wire logic        first_rectifier_drive
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_out_gated: assert property (fourth_pwm_output |-> $past(pwm_d_in))
    else $error("pwm out");
  a_out_falls: assert property ($fell(pwm_d_in) |-> ##[0:2] !fourth_pwm_output)
    else $error("pwm fall");
  a_rect_gated: assert property (first_rectifier_drive |-> $past(ac_sense_input, 3))
    else $error("rect high");
  a_rect_late: assert property ($rose(ac_sense_input) |-> !first_rectifier_drive [*3])
    else $error("rect early");
  a_rect_drop: assert property ($fell(ac_sense_input) |-> ##[1:5] !first_rectifier_drive)
    else $error("rect late");
  a_code_width: assert property (hrdata[31:8] == 24'h0)
    else $error("code width");
endmodule
bind rdt_timing rdt_timing_monitor i_rdt_timing_monitor (
  .hclk                 (hclk),
  .hresetn              (hresetn),
  .hrdata               (hrdata),
  .pwm_d_in             (pwm_d_in),
  .ac_sense_input       (ac_sense_input),
  .fourth_pwm_output    (fourth_pwm_output),
  .first_rectifier_drive(first_rectifier_drive)
);

/* File: testbench/rdt_far_side.sv */
// far side model: cycle generator and sense source
// assumes hclk timing
`timescale 1ns/1ps
module rdt_far_side (
  input wire logic hclk,
  input wire logic hresetn,
  output logic     cycle_start,
  output logic     pwm_d_in,
  output logic     ac_sense_input
);
  logic [6:0] k, s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      k <= 7'h0;
      s <= 7'h0;
    end else begin
      k <= (k == 7'h31) ? 7'h0 : k + 7'h1;
      s <= (s == 7'h63) ? 7'h0 : s + 7'h1;
    end
  end
  assign cycle_start    = (k == 7'h0);
  assign pwm_d_in       = (k < 7'h30);
  assign ac_sense_input = (s > 7'h27);
endmodule

/* File: testbench/testbench.sv */
// bench for the edge placement block
// assumes the far side model drives cycle and sense
`include "rdt_cfg.svh"
`timescale 1ns/1ps
module testbench;
  import rdt_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, sr_q, ac_q;
  logic        cycle_start, pwm_d_in, ac_sense_input, fourth_pwm_output;
  logic        first_rectifier_drive;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0]  idx [3] = '{`RDT_IDX_PWM_D_FALL, `RDT_IDX_RECT1_RISE, `RDT_IDX_RECT1_FALL};
  int          error_cnt, tests_run, tmo, g, f, h, gp, rise_d, fall_l, a, b, c;
  rdt_far_side i_rdt_far_side (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .cycle_start   (cycle_start),
    .pwm_d_in      (pwm_d_in),
    .ac_sense_input(ac_sense_input)
  );
  rdt_timing i_rdt_timing (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (3'h2),
    .hready               (hreadyout),
    .hwdata               (hwdata),
    .hrdata               (hrdata),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .cycle_start          (cycle_start),
    .pwm_d_in             (pwm_d_in),
    .ac_sense_input       (ac_sense_input),
    .fourth_pwm_output    (fourth_pwm_output),
    .first_rectifier_drive(first_rectifier_drive)
  );
  initial begin
    hclk = 0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    tmo <= tmo + 1;
    sr_q <= first_rectifier_drive;
    ac_q <= ac_sense_input;
    g <= fourth_pwm_output ? 0 : g + 1;
    if (cycle_start) gp <= g;
    h <= ac_sense_input ? h + 1 : 0;
    if (first_rectifier_drive && !sr_q) rise_d <= h;
    f <= first_rectifier_drive ? 0 : f + 1;
    if (ac_q && !ac_sense_input) fall_l <= f;
    if (tmo == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({30'h0, hresp, hreadyout}, 32'h1);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic set(input logic [7:0] p, input logic [7:0] u, input logic [7:0] v);
    xfer(1, idx[0], {24'h0, p});
    xfer(1, idx[1], {24'h0, u});
    xfer(1, idx[2], {24'h0, v});
    repeat (300) @(posedge hclk);
  endtask
  task conclude;
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    foreach (idx[j]) begin
      xfer(0, idx[j], 0);
      chk(r, 0);
      xfer(1, idx[j], 32'hffffffff);
      xfer(0, idx[j], 0);
      chk(r, 32'hff);
    end
    xfer(0, 8'h50, 0);
    chk(r, 0);
    $display("register test done");
    set(8'h3c, 8'h14, 8'h14);
    {a, b} = {gp, rise_d};
    set(8'h28, 8'h0a, 8'h0a);
    chk(gp, a);
    chk(rise_d, b);
    xfer(1, `RDT_IDX_CTRL, 1);
    xfer(0, `RDT_IDX_CTRL, 0);
    chk(r, 1);
    set(8'h28, 8'h0a, 8'h0a);
    {a, b, c} = {gp, rise_d, fall_l};
    set(8'h3c, 8'h14, 8'h14);
    chk(gp - a, 10);
    chk(rise_d - b, 5);
    chk(fall_l - c, 5);
    set(8'h29, 8'h14, 8'h14);
    chk(gp - a, 1);
    xfer(0, `RDT_IDX_STATUS, 0);
    chk(r & 32'hffff_fff8, 0);
    $display("timing test done");
    conclude();
  end
endmodule
